// ===== inc/rgc_pkg.sv
// Constants, field layouts and carrier types of the regulator control register bank.
// Assumes APB with 32-bit data; each register index sits at byte address index * 4.
package rgc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_A_MISC = 16'h4068;
  localparam logic [15:0] IDX_A_ON = 16'h4069;
  localparam logic [15:0] IDX_A_SLEEP = 16'h406A;
  localparam logic [15:0] IDX_B_MISC = 16'h406B;
  localparam logic [15:0] IDX_B_ON = 16'h406C;
  localparam logic [15:0] IDX_B_SLEEP = 16'h406D;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h4070;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h4071;
  localparam int ADDR_W_MIN = 18;

  // Decoded register selector
  localparam logic [3:0] SEL_MISC = 4'h0;
  localparam logic [3:0] SEL_ON = 4'h1;
  localparam logic [3:0] SEL_SLEEP = 4'h2;
  localparam logic [3:0] SEL_STATUS = 4'h6;
  localparam logic [3:0] SEL_MASK = 4'h7;
  localparam logic [3:0] SEL_NONE = 4'hF;

  // Misc control fields
  localparam int UV_ACT_HI = 15;
  localparam int UV_ACT_LO = 14;
  localparam int PC_SRC_HI = 12;
  localparam int PC_SRC_LO = 11;
  localparam int PC_VSEL_BIT = 10;
  localparam int PC_MODE_HI = 9;
  localparam int PC_MODE_LO = 8;
  localparam int FLOAT_BIT = 7;
  localparam int BYPASS_BIT = 6;
  localparam int LP_DEPTH_BIT = 0;

  // ON and SLEEP control fields
  localparam int SLOT_HI = 15;
  localparam int SLOT_LO = 13;
  localparam int MODE_BIT = 8;
  localparam int VCODE_HI = 4;
  localparam int VCODE_LO = 0;

  // Reset values and implemented-bit masks
  localparam logic [15:0] MISC_RESET = 16'h0200;
  localparam logic [15:0] ON_RESET = 16'h0000;
  localparam logic [15:0] SLEEP_RESET = 16'h0100;
  localparam logic [15:0] MISC_MASK = 16'hDFC1;
  localparam logic [15:0] SLOT_REG_MASK = 16'hE11F;

  // Field encodings
  localparam logic [2:0] SLOT_NEVER = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_PIN1 = 3'h6;
  localparam logic [2:0] SLOT_PIN2 = 3'h7;
  localparam logic [2:0] SLP_TS5 = 3'h0;
  localparam logic [2:0] SLP_TS3 = 3'h6;
  localparam logic [2:0] SLP_TS1 = 3'h7;
  localparam logic [2:0] TS1 = 3'h1;
  localparam logic [2:0] TS3 = 3'h3;
  localparam logic [2:0] TS5 = 3'h5;
  localparam logic [2:0] SLP_MIRROR = 3'h6;
  localparam logic [1:0] UV_IGNORE = 2'h0;
  localparam logic [1:0] UV_SHUT_REG = 2'h1;
  localparam logic [1:0] UV_SHUT_SYS = 2'h2;
  localparam logic [1:0] PC_OFF = 2'h0;
  localparam logic [1:0] PC_IN1 = 2'h1;
  localparam logic [1:0] PC_IN2 = 2'h2;
  localparam logic [1:0] PC_EITHER = 2'h3;
  localparam logic [1:0] PCM_TURN_OFF = 2'h1;
  localparam logic [1:0] PCM_ON_MODE = 2'h3;

  // Control outputs of one regulator toward the analog block and sequencer
  typedef struct packed {
    logic enable;
    logic [4:0] voltage_code;
    logic low_power;
    logic low_power_depth_sel;
    logic bypass_mode_sel;
    logic discharge;
  } rgc_out_t;

  // Synchronised pin group
  typedef struct packed {
    logic [1:0] undervoltage;
    logic [1:0] pin_control;
    logic [1:0] hw_enable;
  } rgc_pins_t;

endpackage

// ===== design/rgc_regs.sv
// Register bank and decoders controlling two linear regulators, reached over APB.
// Assumes sequencer strobes are on pclk; hardware pins and undervoltage are asynchronous.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps

// Summary of operation
// - With the float bit clear a disabled regulator gets its output discharged, else it floats.
// - The low-power depth bit picks the 50mA or 20mA low-power variant wherever low power applies.
// - ON slot 000 never enables, 001-101 enable in timeslots 1-5, 110/111 follow enable pin 1/2.
// - The ON mode bit picks normal or low-power mode in the ON state and resets to 0.
// - ON voltage codes map 0.90V to 3.30V in 50mV then 100mV steps and reset to 00h.
// - SLEEP slot 000/110/111 move to SLEEP settings in timeslot 5/3/1, 001-101 disable.
// - For a pin-enabled regulator SLEEP codes 001-101 pick the timeslot of entering SLEEP.
// - The SLEEP mode bit picks normal or low-power mode for SLEEP and resets to 1.
// - The SLEEP voltage code uses the ON encoding and resets to zero.
// - Undervoltage action 00 ignores, 01 shuts a timeslot-enabled regulator (a pin-enabled one follows its pin), 10 resets the system, 11 reserved.
// - Every undervoltage event sets its status bit whatever action is selected; irq is raised only if its mask bit is set.
// - Pin-control source 00 off, 01 input 1, 10 input 2, 11 either input.
// - Under pin control the voltage-select bit picks the ON or the SLEEP voltage code.
// - Pin-control mode 00 and 10 select low power and 01 turns the regulator off.
// - Pin-control mode 11 uses the ON mode bit.
module rgc_regs #(
  parameter int ADDR_W = 18,
  parameter int NREG = 2
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer timeslot strobe, same clock
  input wire logic seq_slot_strobe,
  input wire logic [2:0] seq_slot,
  input wire logic seq_sleep,
  // Asynchronous pins
  input wire logic [1:0] hw_enable_pin,
  input wire logic [1:0] pin_control_pin,
  input wire logic [NREG-1:0] undervoltage_pin,
  // Regulator controls
  output rgc_pkg::rgc_out_t [NREG-1:0] reg_ctrl,
  output logic system_reset_req,
  output logic irq
);

  initial begin
    if (ADDR_W < rgc_pkg::ADDR_W_MIN || NREG != 2) begin
      $error("rgc_regs: ADDR_W must be at least 18 and NREG must be 2");
    end
  end

  typedef struct packed {
    logic [NREG-1:0][15:0] misc;
    logic [NREG-1:0][15:0] on;
    logic [NREG-1:0][15:0] slp;
    logic [NREG-1:0] en;
    logic [NREG-1:0] asleep;
    rgc_pkg::rgc_pins_t sync1;
    rgc_pkg::rgc_pins_t sync2;
    logic [NREG-1:0] uv_prev;
    logic [NREG-1:0] status;
    logic [NREG-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rgc_pkg::rgc_out_t [NREG-1:0] out;
    logic sys_rst;
    logic irq;
  } rgc_state_t;

  rgc_state_t st_reg;
  rgc_state_t st_next;

  // Register selector: low three bits are the kind, bit 3 of the result picks regulator B
  function automatic logic [3:0] rgc_decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[17:2];
    if (addr[1:0] != 2'h0 || (ADDR_W > 18 && (addr >> 18) != '0)) begin
      rgc_decode = rgc_pkg::SEL_NONE;
    end else if (idx == rgc_pkg::IDX_A_MISC) begin
      rgc_decode = rgc_pkg::SEL_MISC;
    end else if (idx == rgc_pkg::IDX_A_ON) begin
      rgc_decode = rgc_pkg::SEL_ON;
    end else if (idx == rgc_pkg::IDX_A_SLEEP) begin
      rgc_decode = rgc_pkg::SEL_SLEEP;
    end else if (idx == rgc_pkg::IDX_B_MISC) begin
      rgc_decode = 4'h8 | rgc_pkg::SEL_MISC;
    end else if (idx == rgc_pkg::IDX_B_ON) begin
      rgc_decode = 4'h8 | rgc_pkg::SEL_ON;
    end else if (idx == rgc_pkg::IDX_B_SLEEP) begin
      rgc_decode = 4'h8 | rgc_pkg::SEL_SLEEP;
    end else if (idx == rgc_pkg::IDX_IRQ_STATUS) begin
      rgc_decode = rgc_pkg::SEL_STATUS;
    end else if (idx == rgc_pkg::IDX_IRQ_MASK) begin
      rgc_decode = rgc_pkg::SEL_MASK;
    end else begin
      rgc_decode = rgc_pkg::SEL_NONE;
    end
  endfunction

  // Byte-lane merge restricted to implemented bits
  function automatic logic [15:0] rgc_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [15:0] msk);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    rgc_merge = ((old & ~lanes) | (wd[15:0] & lanes)) & msk;
  endfunction

  logic [3:0] sel;
  logic reg_b;
  logic [2:0] on_code;
  logic [2:0] slp_code;
  logic pin_assigned;
  logic pin_level;
  logic pc_active;
  logic [1:0] pc_mode;
  logic uv_event;
  logic [NREG-1:0] clr;
  logic [NREG-1:0] set;
  logic enabled;

  always_comb begin
    st_next = st_reg;
    sel = rgc_decode(paddr);
    reg_b = sel[3];
    on_code = 3'h0;
    slp_code = 3'h0;
    pin_assigned = 1'b0;
    pin_level = 1'b0;
    pc_active = 1'b0;
    pc_mode = 2'h0;
    uv_event = 1'b0;
    clr = '0;
    set = '0;
    enabled = 1'b0;

    st_next.sync1 = '{undervoltage: undervoltage_pin, pin_control: pin_control_pin,
                      hw_enable: hw_enable_pin};
    st_next.sync2 = st_reg.sync1;
    st_next.uv_prev = st_reg.sync2.undervoltage;
    st_next.sys_rst = 1'b0;

    // Zero-wait slave: ready is raised for the access phase following each setup
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      st_next.pready = 1'b1;
      if (sel == rgc_pkg::SEL_NONE) begin
        st_next.pslverr = 1'b1;
      end else if (!pwrite) begin
        case (sel[2:0])
          rgc_pkg::SEL_MISC[2:0]: st_next.prdata = {16'h0000, st_reg.misc[reg_b]};
          rgc_pkg::SEL_ON[2:0]: st_next.prdata = {16'h0000, st_reg.on[reg_b]};
          rgc_pkg::SEL_SLEEP[2:0]: st_next.prdata = {16'h0000, st_reg.slp[reg_b]};
          rgc_pkg::SEL_STATUS[2:0]: st_next.prdata = {30'h0000_0000, st_reg.status};
          rgc_pkg::SEL_MASK[2:0]: st_next.prdata = {30'h0000_0000, st_reg.mask};
          default: st_next.prdata = 32'h0000_0000;
        endcase
      end
    end

    if (psel && penable && st_reg.pready && pwrite && sel != rgc_pkg::SEL_NONE) begin
      case (sel[2:0])
        rgc_pkg::SEL_MISC[2:0]: begin
          st_next.misc[reg_b] = rgc_merge(st_reg.misc[reg_b], pwdata, pstrb,
                                          rgc_pkg::MISC_MASK);
        end
        rgc_pkg::SEL_ON[2:0]: begin
          st_next.on[reg_b] = rgc_merge(st_reg.on[reg_b], pwdata, pstrb,
                                        rgc_pkg::SLOT_REG_MASK);
        end
        rgc_pkg::SEL_SLEEP[2:0]: begin
          st_next.slp[reg_b] = rgc_merge(st_reg.slp[reg_b], pwdata, pstrb,
                                         rgc_pkg::SLOT_REG_MASK);
        end
        rgc_pkg::SEL_STATUS[2:0]: begin
          if (pstrb[0]) begin
            clr = pwdata[NREG-1:0];
          end
        end
        rgc_pkg::SEL_MASK[2:0]: begin
          if (pstrb[0]) begin
            st_next.mask = pwdata[NREG-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < NREG; i++) begin
      on_code = st_reg.on[i][rgc_pkg::SLOT_HI:rgc_pkg::SLOT_LO];
      slp_code = st_reg.slp[i][rgc_pkg::SLOT_HI:rgc_pkg::SLOT_LO];
      pin_assigned = (on_code == rgc_pkg::SLOT_PIN1) || (on_code == rgc_pkg::SLOT_PIN2);
      pin_level = (on_code == rgc_pkg::SLOT_PIN1) ? st_reg.sync2.hw_enable[0]
                                                  : st_reg.sync2.hw_enable[1];

      // Timeslot sequencing
      if (seq_slot_strobe && !seq_sleep) begin
        if (on_code != rgc_pkg::SLOT_NEVER && on_code <= rgc_pkg::SLOT_LAST &&
            seq_slot == on_code) begin
          st_next.en[i] = 1'b1;
          st_next.asleep[i] = 1'b0;
        end else if (pin_assigned && seq_slot == rgc_pkg::TS1) begin
          st_next.asleep[i] = 1'b0;
        end
      end else if (seq_slot_strobe && seq_sleep) begin
        if (slp_code != rgc_pkg::SLP_TS5 && slp_code <= rgc_pkg::SLOT_LAST) begin
          // Code n acts in timeslot 6-n, so 100 is slot 2 and 101 is slot 1
          if (seq_slot == rgc_pkg::SLP_MIRROR - slp_code) begin
            if (pin_assigned) begin
              st_next.asleep[i] = 1'b1;
            end else begin
              st_next.en[i] = 1'b0;
            end
          end
        end else if ((slp_code == rgc_pkg::SLP_TS5 && seq_slot == rgc_pkg::TS5) ||
                     (slp_code == rgc_pkg::SLP_TS3 && seq_slot == rgc_pkg::TS3) ||
                     (slp_code == rgc_pkg::SLP_TS1 && seq_slot == rgc_pkg::TS1)) begin
          st_next.asleep[i] = 1'b1;
        end
      end

      // Undervoltage: rising edge of the synchronised flag
      uv_event = st_reg.sync2.undervoltage[i] && !st_reg.uv_prev[i];
      if (uv_event) begin
        set[i] = 1'b1;
        case (st_reg.misc[i][rgc_pkg::UV_ACT_HI:rgc_pkg::UV_ACT_LO])
          rgc_pkg::UV_SHUT_REG: st_next.en[i] = 1'b0;
          rgc_pkg::UV_SHUT_SYS: st_next.sys_rst = 1'b1;
          default: begin
          end
        endcase
      end

      // Pin-control source
      case (st_reg.misc[i][rgc_pkg::PC_SRC_HI:rgc_pkg::PC_SRC_LO])
        rgc_pkg::PC_IN1: pc_active = st_reg.sync2.pin_control[0];
        rgc_pkg::PC_IN2: pc_active = st_reg.sync2.pin_control[1];
        rgc_pkg::PC_EITHER: pc_active = |st_reg.sync2.pin_control;
        default: pc_active = 1'b0;
      endcase
      pc_mode = st_reg.misc[i][rgc_pkg::PC_MODE_HI:rgc_pkg::PC_MODE_LO];

      // A pin-enabled regulator follows its pin; an undervoltage shutdown does not latch it off
      enabled = pin_assigned ? pin_level : st_reg.en[i];
      if (pc_active) begin
        st_next.out[i].voltage_code = st_reg.misc[i][rgc_pkg::PC_VSEL_BIT]
            ? st_reg.slp[i][rgc_pkg::VCODE_HI:rgc_pkg::VCODE_LO]
            : st_reg.on[i][rgc_pkg::VCODE_HI:rgc_pkg::VCODE_LO];
        if (pc_mode == rgc_pkg::PCM_TURN_OFF) begin
          enabled = 1'b0;
        end
        st_next.out[i].low_power = (pc_mode == rgc_pkg::PCM_ON_MODE)
            ? st_reg.on[i][rgc_pkg::MODE_BIT] : 1'b1;
      end else if (st_reg.asleep[i]) begin
        st_next.out[i].voltage_code = st_reg.slp[i][rgc_pkg::VCODE_HI:rgc_pkg::VCODE_LO];
        st_next.out[i].low_power = st_reg.slp[i][rgc_pkg::MODE_BIT];
      end else begin
        st_next.out[i].voltage_code = st_reg.on[i][rgc_pkg::VCODE_HI:rgc_pkg::VCODE_LO];
        st_next.out[i].low_power = st_reg.on[i][rgc_pkg::MODE_BIT];
      end
      st_next.out[i].enable = enabled;
      st_next.out[i].low_power_depth_sel = st_reg.misc[i][rgc_pkg::LP_DEPTH_BIT];
      st_next.out[i].bypass_mode_sel = st_reg.misc[i][rgc_pkg::BYPASS_BIT];
      st_next.out[i].discharge = !enabled && !st_reg.misc[i][rgc_pkg::FLOAT_BIT];
    end

    // A new event in the clearing cycle keeps its bit
    st_next.status = (st_reg.status & ~clr) | set;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      for (int i = 0; i < NREG; i++) begin
        st_reg.misc[i] <= rgc_pkg::MISC_RESET;
        st_reg.on[i] <= rgc_pkg::ON_RESET;
        st_reg.slp[i] <= rgc_pkg::SLEEP_RESET;
        st_reg.out[i].discharge <= 1'b1;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign reg_ctrl = st_reg.out;
  assign system_reset_req = st_reg.sys_rst;
  assign irq = st_reg.irq;

endmodule

// ===== verification/rgc_checker.sv
// Port-level assertions for the regulator control register bank.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
module rgc_checker #(
  parameter int NREG = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Regulator side
  input wire rgc_pkg::rgc_out_t [NREG-1:0] reg_ctrl,
  input wire logic system_reset_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans;
    psel && !penable |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_noans;
    !(psel && !penable) |=> !pready;
  endproperty
  a_noans: assert property (p_noans) else $error("answer without setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_rdz;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_dis0;
    reg_ctrl[0].enable |-> !reg_ctrl[0].discharge;
  endproperty
  a_dis0: assert property (p_dis0) else $error("discharge while enabled");
  property p_dis1;
    reg_ctrl[1].enable |-> !reg_ctrl[1].discharge;
  endproperty
  a_dis1: assert property (p_dis1) else $error("discharge while enabled");
  property p_sys;
    system_reset_req |=> !system_reset_req;
  endproperty
  a_sys: assert property (p_sys) else $error("reset request not a pulse");
  c_err: cover property (pslverr);
  c_sleep: cover property (reg_ctrl[1].enable && reg_ctrl[1].low_power);
  c_sys: cover property (system_reset_req);
endmodule
bind rgc_regs rgc_checker #(.NREG(NREG)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reg_ctrl(reg_ctrl), .system_reset_req(system_reset_req));

// ===== verification/rgc_seq_model.sv
// Power-up sequencer stand-in: strobes timeslots 1 to 5 of an ON or SLEEP sequence.
// Assumes the strobe is sampled on pclk; gaps leave time for the two-edge answer.
`timescale 1ns/1ps
module rgc_seq_model (
  // Clock
  input wire logic pclk,
  // Timeslot strobe
  output logic seq_slot_strobe,
  output logic [2:0] seq_slot,
  output logic seq_sleep
);
  initial begin
    seq_slot_strobe = 1'b0;
    seq_slot = 3'h0;
    seq_sleep = 1'b0;
  end
  task automatic run(input logic slp);
    for (int s = 1; s <= 5; s++) begin
      @(posedge pclk);
      seq_slot_strobe <= 1'b1;
      seq_slot <= 3'(s);
      seq_sleep <= slp;
      @(posedge pclk);
      seq_slot_strobe <= 1'b0;
      // Slot value moves off so a stale slot is never mistaken for a new one
      seq_slot <= 3'h0;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// ===== verification/tb_rgc_regs.sv
// Self-checking bench for the regulator control register bank.
// Assumes APB answers within a bounded wait and pins are synced inside the block.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb_rgc_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [1:0] pc_pin = '0;
  logic [1:0] hw_en = '0;
  logic [1:0] uv = '0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, srst, irq, strobe, sleep;
  wire logic [2:0] slot;
  rgc_pkg::rgc_out_t [1:0] ctl;
  int errors = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  always #50 pclk = ~pclk;
  rgc_seq_model seq (.pclk(pclk), .seq_slot_strobe(strobe), .seq_slot(slot), .seq_sleep(sleep));
  rgc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_slot_strobe(strobe), .seq_slot(slot),
    .seq_sleep(sleep), .hw_enable_pin(hw_en), .pin_control_pin(pc_pin),
    .undervoltage_pin(uv), .reg_ctrl(ctl), .system_reset_req(srst), .irq(irq));
  task results;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("[ERR] %0t bus wait ran out", $time);
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [15:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    `CHK(rd, {16'h0000, exp})
  endtask
  task t_reset;
    rd_chk(rgc_pkg::IDX_A_MISC, 16'h0200);
    rd_chk(rgc_pkg::IDX_A_ON, 16'h0000);
    rd_chk(rgc_pkg::IDX_A_SLEEP, 16'h0100);
    rd_chk(rgc_pkg::IDX_B_MISC, 16'h0200);
    apb(1'b0, 16'h4080, 16'h0000);
    `CHK(er, 1'b1)
  endtask
  task t_bits;
    apb(1'b1, rgc_pkg::IDX_A_MISC, 16'hFFFF);
    rd_chk(rgc_pkg::IDX_A_MISC, 16'hDFC1);
    apb(1'b1, rgc_pkg::IDX_B_SLEEP, 16'hFFFF);
    rd_chk(rgc_pkg::IDX_B_SLEEP, 16'hE11F);
    apb(1'b1, rgc_pkg::IDX_A_MISC, 16'h0200);
  endtask
  task t_on;
    apb(1'b1, rgc_pkg::IDX_A_ON, 16'h600E);
    apb(1'b1, rgc_pkg::IDX_A_SLEEP, 16'h8007);
    apb(1'b1, rgc_pkg::IDX_B_ON, 16'h2005);
    apb(1'b1, rgc_pkg::IDX_B_SLEEP, 16'h011F);
    seq.run(1'b0);
    #1;
    `CHK(ctl[0].enable, 1'b1)
    `CHK(ctl[0].voltage_code, 5'h0E)
    `CHK(ctl[0].low_power, 1'b0)
    `CHK(ctl[0].discharge, 1'b0)
    `CHK(ctl[1].enable, 1'b1)
    `CHK(ctl[1].voltage_code, 5'h05)
  endtask
  task t_pin;
    apb(1'b1, rgc_pkg::IDX_A_MISC, 16'h0F00);
    pc_pin <= 2'b01;
    repeat (5) @(posedge pclk);
    #1;
    `CHK(ctl[0].voltage_code, 5'h07)
    `CHK(ctl[0].low_power, 1'b0)
    apb(1'b1, rgc_pkg::IDX_A_MISC, 16'h0D01);
    repeat (3) @(posedge pclk);
    #1;
    `CHK(ctl[0].enable, 1'b0)
    `CHK(ctl[0].discharge, 1'b1)
    `CHK(ctl[0].low_power_depth_sel, 1'b1)
    pc_pin <= 2'b00;
    apb(1'b1, rgc_pkg::IDX_A_MISC, 16'h0200);
  endtask
  task t_sleep;
    seq.run(1'b1);
    #1;
    `CHK(ctl[0].enable, 1'b0)
    `CHK(ctl[1].enable, 1'b1)
    `CHK(ctl[1].low_power, 1'b1)
    `CHK(ctl[1].voltage_code, 5'h1F)
  endtask
  // Regulator B handed to enable pin 1, then pin control through either input
  task t_hwen;
    apb(1'b1, rgc_pkg::IDX_B_ON, 16'hC003);
    apb(1'b1, rgc_pkg::IDX_B_SLEEP, 16'h611F);
    apb(1'b1, rgc_pkg::IDX_B_MISC, 16'h1A40);
    hw_en <= 2'b01;
    repeat (5) @(posedge pclk);
    #1;
    `CHK(ctl[1].enable, 1'b1)
    `CHK(ctl[1].bypass_mode_sel, 1'b1)
    pc_pin <= 2'b10;
    repeat (5) @(posedge pclk);
    #1;
    `CHK(ctl[1].voltage_code, 5'h03)
    `CHK(ctl[1].low_power, 1'b1)
    `CHK(ctl[1].enable, 1'b1)
    pc_pin <= 2'b00;
    seq.run(1'b0);
    #1;
    `CHK(ctl[1].low_power, 1'b0)
    `CHK(ctl[1].voltage_code, 5'h03)
    seq.run(1'b1);
    #1;
    `CHK(ctl[1].enable, 1'b1)
    `CHK(ctl[1].voltage_code, 5'h1F)
    hw_en <= 2'b00;
    repeat (5) @(posedge pclk);
    #1;
    `CHK(ctl[1].enable, 1'b0)
    `CHK(ctl[1].discharge, 1'b1)
  endtask
  task t_irq;
    logic seen;
    seen = 1'b0;
    apb(1'b1, rgc_pkg::IDX_IRQ_MASK, 16'h0001);
    uv <= 2'b01;
    repeat (6) @(posedge pclk);
    `CHK(irq, 1'b1)
    rd_chk(rgc_pkg::IDX_IRQ_STATUS, 16'h0001);
    apb(1'b1, rgc_pkg::IDX_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, rgc_pkg::IDX_B_MISC, 16'h8200);
    uv <= 2'b11;
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      if (srst === 1'b1)
        seen = 1'b1;
    end
    `CHK(seen, 1'b1)
    `CHK(irq, 1'b0)
    rd_chk(rgc_pkg::IDX_IRQ_STATUS, 16'h0002);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bits();
    t_on();
    t_pin();
    t_sleep();
    t_hwen();
    t_irq();
    results();
  end
endmodule
